// ### pkg/pmae_defs.svh
/*
 * Constants for the power-management activity detector: register offsets,
 * field positions, reset values, write masks and monitored address windows.
 * Assumes byte-wide register access and 16-bit ISA I/O addresses.
 */
`ifndef PMAE_DEFS_SVH
`define PMAE_DEFS_SVH

// register offsets, one byte each
`define PMAE_OFS_SELECT     8'h68
`define PMAE_OFS_EN_A0      8'h6c
`define PMAE_OFS_EN_A1      8'h6d
`define PMAE_OFS_EN_A2      8'h6e
`define PMAE_OFS_EN_A3      8'h6f
`define PMAE_OFS_EN_B0      8'h70
`define PMAE_OFS_EN_B1      8'h71
`define PMAE_OFS_EN_C0      8'h72
`define PMAE_OFS_EN_C1      8'h73
`define PMAE_OFS_WAKE       8'h74
`define PMAE_OFS_INTERVAL   8'h75
`define PMAE_OFS_THRESHOLD  8'h76
`define PMAE_OFS_SMI_CTL    8'h77

// reset values
`define PMAE_RST_BYTE       8'h00
`define PMAE_RST_EN_A       32'h0000_0000
`define PMAE_RST_EN_B       16'h0000
`define PMAE_RST_EN_C       16'h0000

// writable bits; reserved bits read zero
`define PMAE_MASK_SELECT    8'h07
`define PMAE_MASK_EN_A      32'h1fbf_ffff
`define PMAE_MASK_EN_B      16'h3fff
`define PMAE_MASK_EN_C      16'h000d
`define PMAE_MASK_WAKE      8'h33
`define PMAE_MASK_THRESHOLD 8'h7f
`define PMAE_MASK_SMI_CTL   8'h10

// select register fields
`define PMAE_SEL_FDD        0
`define PMAE_SEL_LPT_LO     1
`define PMAE_SEL_LPT_HI     2

// enable register A fields
`define PMAE_A_KBD_IRQ12    28
`define PMAE_A_KBD_IRQ1     27
`define PMAE_A_FDD_DRQ2     26
`define PMAE_A_VID_GFX      25
`define PMAE_A_VID_CS       24
`define PMAE_A_VID_AB       23
`define PMAE_A_AUD_DRQ_HI   21
`define PMAE_A_AUD_DRQ_LO   16
`define PMAE_A_AUD_WIN_HI   15
`define PMAE_A_AUD_WIN_LO   2
`define PMAE_A_SEC_IDE      1
`define PMAE_A_PRI_IDE      0

// enable register B fields
`define PMAE_B_IOGC_RANGE   13
`define PMAE_B_IOGC_62_66   12
`define PMAE_B_LPT_DRQ      11
`define PMAE_B_WIN_HI       10
`define PMAE_B_WIN_LO       0

// enable register C fields
`define PMAE_C_VID_GPI      3
`define PMAE_C_AUD_GPI      2
`define PMAE_C_PRI_GPI      0

// wake status, threshold and smi control fields
`define PMAE_WAKE_RTC       5
`define PMAE_WAKE_PWR       4
`define PMAE_WAKE_RING      1
`define PMAE_WAKE_DRQ2      0
`define PMAE_THR_ENABLE     6
`define PMAE_SMI_READ_CLR   4

// standby monitor enable bits that arm each wake source
`define PMAE_MON_RTC        8
`define PMAE_MON_PWR        21
`define PMAE_MON_RING       9
`define PMAE_MON_FLOPPY     4

// windows: audio bits 15..2, parallel bits 10..8, serial bits 7..0
`define PMAE_WIN_COUNT      25
`define PMAE_WIN_LO { \
   16'h0f40, 16'h0e80, 16'h0604, 16'h0530, 16'h0280, 16'h0260, 16'h0240, \
   16'h0220, 16'h0330, 16'h0320, 16'h0310, 16'h0300, 16'h0338, 16'h0200, \
   16'h03bc, 16'h0278, 16'h0378, \
   16'h0338, 16'h0238, 16'h0228, 16'h0220, 16'h02e8, 16'h03e8, 16'h02f8, \
   16'h03f8 }
`define PMAE_WIN_HI { \
   16'h0f47, 16'h0e87, 16'h060b, 16'h0537, 16'h0293, 16'h0273, 16'h0253, \
   16'h0233, 16'h0333, 16'h0323, 16'h0313, 16'h0303, 16'h033b, 16'h0207, \
   16'h03be, 16'h027f, 16'h037f, \
   16'h033f, 16'h023f, 16'h022f, 16'h0227, 16'h02ef, 16'h03ef, 16'h02ff, \
   16'h03ff }
`define PMAE_AUD_WIN_FIRST  11
`define PMAE_LPT_WIN_FIRST  8

// fixed ranges
`define PMAE_FDD_PRI_LO     16'h03f0
`define PMAE_FDD_PRI_HI     16'h03f7
`define PMAE_FDD_SEC_LO     16'h0370
`define PMAE_FDD_SEC_HI     16'h0377
`define PMAE_GFX_LO         16'h03b0
`define PMAE_GFX_HI         16'h03df
`define PMAE_PORT_62        16'h0062
`define PMAE_PORT_66        16'h0066
`define PMAE_AB_PAGE_TAG    3'h5

// idle pin levels: active-low lines high, the rest low
`define PMAE_PIN_IDLE       21'h00_040d

`endif

// ### pkg/pmae_pkg.sv
/*
 * Types shared by the activity detector: bus access carriers, the pin
 * bundle, the event bundle and the bus-activity measuring states.
 * Assumes the I/O and memory carriers come from logic on the same clock.
 */
`default_nettype none

package pmae_pkg;

   // one decoded i/o cycle
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
   } pmae_io_access_type;

   // one decoded memory cycle
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } pmae_mem_access_type;

   // asynchronous pins, synchronised inside the block
   typedef struct packed {
      logic [7:0] drq_req;
      logic       irq1;
      logic       irq12;
      logic       video_chip_select_pin_n;
      logic [3:0] general_purpose_input;
      logic       primary_ide_dma_request;
      logic       secondary_ide_dma_request;
      logic       rtc_interrupt_input_n;
      logic       power_button_input_n;
      logic       ring_indicate;
      logic       target_ready_n;
   } pmae_pin_type;

   // registered device-class activity events, high while the source is active
   typedef struct packed {
      logic primary_hdd;
      logic secondary_hdd;
      logic audio;
      logic video;
      logic floppy;
      logic serial;
      logic parallel;
      logic keyboard;
      logic io_group_c_detect;
      logic bus_activity_event;
   } pmae_event_type;

   // bus activity measuring states
   typedef enum logic [0:0] {
      BA_IDLE,
      BA_MEASURE
   } pmae_ba_state_type;

endpackage

`default_nettype wire

// ### core/pmae_activity_detect.sv
/*
 * Power-management activity detector: turns i/o windows, dma requests,
 * interrupt lines and general inputs into device-class activity events,
 * measures bus activity, and records which source woke the system.
 * Assumes io/mem carriers and standby inputs are on mclk; pins are not.
 */
// Our own choice: the address-and-strobe port.
`include "pmae_defs.svh"
`default_nettype none

module pmae_activity_detect #(
   parameter int IV_W = 8,
   parameter int TH_W = 6
) (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          reset,
   // register port
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   input  wire logic                          reg_write,
   input  wire logic                          reg_read,
   output logic [7:0]                         reg_rdata,
   // decoded bus traffic
   input  wire pmae_pkg::pmae_io_access_type  io_access,
   input  wire pmae_pkg::pmae_mem_access_type mem_access,
   input  wire logic                          io_group_c_hit,
   // asynchronous pins
   input  wire pmae_pkg::pmae_pin_type        pins,
   // standby timer interface
   input  wire logic [31:0]                   standby_monitor_enable,
   input  wire logic                          standby_expired,
   // results
   output var  pmae_pkg::pmae_event_type      activity_events,
   output logic                               standby_to_on_smi
);

   if (IV_W != 8 || TH_W != 6 || TH_W >= IV_W) begin : g_chk
      $error("pmae_activity_detect: widths must be 8 and 6");
   end

   logic [7:0]                  select_ff;
   logic [31:0]                 en_a_ff;
   logic [15:0]                 en_b_ff;
   logic [15:0]                 en_c_ff;
   logic [7:0]                  wake_ff;
   logic [IV_W-1:0]             interval_ff;
   logic [7:0]                  threshold_ff;
   logic [7:0]                  smi_ctl_ff;
   logic [7:0]                  nxt_rdata;
   logic [7:0]                  rdata_ff;
   pmae_pkg::pmae_pin_type      pin_meta_ff;
   pmae_pkg::pmae_pin_type      pin_sync_ff;
   pmae_pkg::pmae_event_type    nxt_events;
   pmae_pkg::pmae_event_type    events_ff;
   pmae_pkg::pmae_ba_state_type ba_state_ff;
   logic [IV_W-1:0]             tick_ff;
   logic [IV_W-1:0]             trdy_cnt_ff;
   logic [IV_W-1:0]             trdy_total;
   logic                        ba_end;
   logic                        ba_hit_ff;
   logic [`PMAE_WIN_COUNT-1:0]  win_en;
   logic [`PMAE_WIN_COUNT-1:0]  win_hit;
   logic [16*`PMAE_WIN_COUNT-1:0] win_lo;
   logic [16*`PMAE_WIN_COUNT-1:0] win_hi;
   logic                        fdd_hit;
   logic                        gfx_hit;
   logic                        ab_hit;
   logic                        port_62_66;
   logic                        lpt_drq;
   logic [5:0]                  aud_drq;
   logic [7:0]                  wake_set;
   logic [7:0]                  wake_clr;
   logic                        smi_ff;
   logic                        wr_wake;

   // register writes, select register in a process of its own
   always_ff @(posedge mclk) begin
      if (reset)
         select_ff <= `PMAE_RST_BYTE;
      else if (reg_write && reg_addr == `PMAE_OFS_SELECT)
         select_ff <= reg_wdata & `PMAE_MASK_SELECT;
   end

   // enable register a, written one byte lane at a time
   always_ff @(posedge mclk) begin
      if (reset) begin
         en_a_ff <= `PMAE_RST_EN_A;
      end else if (reg_write) begin
         case (reg_addr)
            `PMAE_OFS_EN_A0: en_a_ff[7:0]   <= reg_wdata;
            `PMAE_OFS_EN_A1: en_a_ff[15:8]  <= reg_wdata;
            `PMAE_OFS_EN_A2:
               en_a_ff[23:16] <= reg_wdata & 8'(`PMAE_MASK_EN_A >> 16);
            `PMAE_OFS_EN_A3:
               en_a_ff[31:24] <= reg_wdata & 8'(`PMAE_MASK_EN_A >> 24);
            default: en_a_ff <= en_a_ff;
         endcase
      end
   end

   // enable registers b and c
   always_ff @(posedge mclk) begin
      if (reset) begin
         en_b_ff <= `PMAE_RST_EN_B;
         en_c_ff <= `PMAE_RST_EN_C;
      end else if (reg_write) begin
         case (reg_addr)
            `PMAE_OFS_EN_B0: en_b_ff[7:0]  <= reg_wdata;
            `PMAE_OFS_EN_B1:
               en_b_ff[15:8] <= reg_wdata & 8'(`PMAE_MASK_EN_B >> 8);
            `PMAE_OFS_EN_C0:
               en_c_ff[7:0]  <= reg_wdata & 8'(`PMAE_MASK_EN_C);
            default: begin
               en_b_ff <= en_b_ff;
               en_c_ff <= en_c_ff;
            end
         endcase
      end
   end

   // interval, threshold and read-clear control
   always_ff @(posedge mclk) begin
      if (reset) begin
         interval_ff  <= `PMAE_RST_BYTE;
         threshold_ff <= `PMAE_RST_BYTE;
         smi_ctl_ff   <= `PMAE_RST_BYTE;
      end else if (reg_write) begin
         if (reg_addr == `PMAE_OFS_INTERVAL)
            interval_ff <= reg_wdata;
         if (reg_addr == `PMAE_OFS_THRESHOLD)
            threshold_ff <= reg_wdata & `PMAE_MASK_THRESHOLD;
         if (reg_addr == `PMAE_OFS_SMI_CTL)
            smi_ctl_ff <= reg_wdata & `PMAE_MASK_SMI_CTL;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (reg_addr)
         `PMAE_OFS_SELECT:    nxt_rdata = select_ff;
         `PMAE_OFS_EN_A0:     nxt_rdata = en_a_ff[7:0];
         `PMAE_OFS_EN_A1:     nxt_rdata = en_a_ff[15:8];
         `PMAE_OFS_EN_A2:     nxt_rdata = en_a_ff[23:16];
         `PMAE_OFS_EN_A3:     nxt_rdata = en_a_ff[31:24];
         `PMAE_OFS_EN_B0:     nxt_rdata = en_b_ff[7:0];
         `PMAE_OFS_EN_B1:     nxt_rdata = en_b_ff[15:8];
         `PMAE_OFS_EN_C0:     nxt_rdata = en_c_ff[7:0];
         `PMAE_OFS_EN_C1:     nxt_rdata = en_c_ff[15:8];
         `PMAE_OFS_WAKE:      nxt_rdata = wake_ff;
         `PMAE_OFS_INTERVAL:  nxt_rdata = interval_ff;
         `PMAE_OFS_THRESHOLD: nxt_rdata = threshold_ff;
         `PMAE_OFS_SMI_CTL:   nxt_rdata = smi_ctl_ff;
         default:             nxt_rdata = `PMAE_RST_BYTE;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset || !reg_read)
         rdata_ff <= `PMAE_RST_BYTE;
      else
         rdata_ff <= nxt_rdata;
   end
   assign reg_rdata = rdata_ff;

   // two-stage synchroniser for every pin
   always_ff @(posedge mclk) begin
      if (reset) begin
         pin_meta_ff <= `PMAE_PIN_IDLE; // idle, so no false wake
         pin_sync_ff <= `PMAE_PIN_IDLE;
      end else begin
         pin_meta_ff <= pins;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // monitored i/o windows, one comparator pair per window
   assign win_lo = `PMAE_WIN_LO;
   assign win_hi = `PMAE_WIN_HI;
   assign win_en = {en_a_ff[`PMAE_A_AUD_WIN_HI:`PMAE_A_AUD_WIN_LO],
                    en_b_ff[`PMAE_B_WIN_HI:`PMAE_B_WIN_LO]};
   for (genvar gi = 0; gi < `PMAE_WIN_COUNT; gi++) begin : g_win
      assign win_hit[gi] = io_access.valid && win_en[gi] &&
                           io_access.addr >= win_lo[gi*16 +: 16] &&
                           io_access.addr <= win_hi[gi*16 +: 16];
   end

   // fixed ranges
   always_comb begin
      if (select_ff[`PMAE_SEL_FDD])
         fdd_hit = io_access.addr >= `PMAE_FDD_SEC_LO &&
                   io_access.addr <= `PMAE_FDD_SEC_HI;
      else
         fdd_hit = io_access.addr >= `PMAE_FDD_PRI_LO &&
                   io_access.addr <= `PMAE_FDD_PRI_HI;
      fdd_hit    = fdd_hit && io_access.valid;
      gfx_hit    = io_access.valid && io_access.addr >= `PMAE_GFX_LO &&
                   io_access.addr <= `PMAE_GFX_HI;
      ab_hit     = mem_access.valid &&
                   mem_access.addr[19:17] == `PMAE_AB_PAGE_TAG;
      port_62_66 = io_access.valid && (io_access.addr == `PMAE_PORT_62 ||
                   io_access.addr == `PMAE_PORT_66);
   end

   // parallel-port dma request select
   always_comb begin
      case (select_ff[`PMAE_SEL_LPT_HI:`PMAE_SEL_LPT_LO])
         2'h0:    lpt_drq = pin_sync_ff.drq_req[0];
         2'h1:    lpt_drq = pin_sync_ff.drq_req[1];
         2'h2:    lpt_drq = pin_sync_ff.drq_req[3];
         default: lpt_drq = 1'b0;
      endcase
   end

   // audio dma requests in enable-bit order 7,6,5,3,1,0
   assign aud_drq = {pin_sync_ff.drq_req[7:5], pin_sync_ff.drq_req[3],
                     pin_sync_ff.drq_req[1:0]};

   // device-class event combine
   always_comb begin
      nxt_events.keyboard =
         (en_a_ff[`PMAE_A_KBD_IRQ12] && pin_sync_ff.irq12) ||
         (en_a_ff[`PMAE_A_KBD_IRQ1] && pin_sync_ff.irq1);
      nxt_events.floppy =
         (en_a_ff[`PMAE_A_FDD_DRQ2] && pin_sync_ff.drq_req[2]) ||
         fdd_hit;
      nxt_events.video =
         (en_a_ff[`PMAE_A_VID_GFX] && gfx_hit) ||
         (en_a_ff[`PMAE_A_VID_CS] &&
          !pin_sync_ff.video_chip_select_pin_n) ||
         (en_a_ff[`PMAE_A_VID_AB] && ab_hit) ||
         (en_c_ff[`PMAE_C_VID_GPI] &&
          pin_sync_ff.general_purpose_input[3]);
      nxt_events.audio =
         (|(en_a_ff[`PMAE_A_AUD_DRQ_HI:`PMAE_A_AUD_DRQ_LO] & aud_drq)) ||
         (|win_hit[`PMAE_WIN_COUNT-1:`PMAE_AUD_WIN_FIRST]) ||
         (en_c_ff[`PMAE_C_AUD_GPI] &&
          pin_sync_ff.general_purpose_input[2]);
      nxt_events.primary_hdd =
         (en_a_ff[`PMAE_A_PRI_IDE] && pin_sync_ff.primary_ide_dma_request) ||
         (en_c_ff[`PMAE_C_PRI_GPI] &&
          pin_sync_ff.general_purpose_input[0]);
      nxt_events.secondary_hdd = en_a_ff[`PMAE_A_SEC_IDE] &&
         pin_sync_ff.secondary_ide_dma_request;
      nxt_events.parallel = (en_b_ff[`PMAE_B_LPT_DRQ] && lpt_drq) ||
         (|win_hit[`PMAE_AUD_WIN_FIRST-1:`PMAE_LPT_WIN_FIRST]);
      nxt_events.serial = |win_hit[`PMAE_LPT_WIN_FIRST-1:0];
      nxt_events.io_group_c_detect =
         (en_b_ff[`PMAE_B_IOGC_RANGE] && io_group_c_hit) ||
         (en_b_ff[`PMAE_B_IOGC_62_66] && port_62_66);
      nxt_events.bus_activity_event = ba_hit_ff;
   end

   // event outputs registered
   always_ff @(posedge mclk) begin
      if (reset)
         events_ff <= '0;
      else
         events_ff <= nxt_events;
   end
   assign activity_events = events_ff;

   // bus activity: count target-ready over interval cycles
   assign ba_end     = tick_ff == interval_ff - 1'b1;
   assign trdy_total = trdy_cnt_ff +
                       IV_W'(!pin_sync_ff.target_ready_n);
   always_ff @(posedge mclk) begin
      if (reset || interval_ff == '0 ||
          !threshold_ff[`PMAE_THR_ENABLE]) begin
         ba_state_ff <= pmae_pkg::BA_IDLE;
         tick_ff     <= '0;
         trdy_cnt_ff <= '0;
         ba_hit_ff   <= 1'b0;
      end else begin
         case (ba_state_ff)
            pmae_pkg::BA_IDLE: begin
               ba_state_ff <= pmae_pkg::BA_MEASURE;
               ba_hit_ff   <= 1'b0;
            end
            pmae_pkg::BA_MEASURE: begin
               if (ba_end) begin
                  tick_ff     <= '0;
                  trdy_cnt_ff <= '0;
                  ba_hit_ff   <= trdy_total >
                                 IV_W'(threshold_ff[TH_W-1:0]);
               end else begin
                  tick_ff     <= tick_ff + 1'b1;
                  trdy_cnt_ff <= trdy_total;
                  ba_hit_ff   <= 1'b0;
               end
            end
            default: ba_state_ff <= pmae_pkg::BA_IDLE;
         endcase
      end
   end

   // wake sources armed by the standby monitor enables
   always_comb begin
      wake_set = '0;
      wake_set[`PMAE_WAKE_RTC]  = !pin_sync_ff.rtc_interrupt_input_n &&
                                  standby_monitor_enable[`PMAE_MON_RTC];
      wake_set[`PMAE_WAKE_PWR]  = !pin_sync_ff.power_button_input_n &&
                                  standby_monitor_enable[`PMAE_MON_PWR];
      wake_set[`PMAE_WAKE_RING] = pin_sync_ff.ring_indicate &&
                                  standby_monitor_enable[`PMAE_MON_RING];
      wake_set[`PMAE_WAKE_DRQ2] = pin_sync_ff.drq_req[2] &&
                                  standby_monitor_enable[`PMAE_MON_FLOPPY];
      wake_set = standby_expired ? wake_set : '0;
   end

   // standby-to-on smi, registered, high while standby has expired and an armed wake source is active
   always_ff @(posedge mclk) begin
      if (reset)
         smi_ff <= 1'b0;
      else
         smi_ff <= |wake_set;
   end
   assign standby_to_on_smi = smi_ff;

   // wake status: write one clears, read clears when enabled, set wins
   assign wr_wake = reg_write && reg_addr == `PMAE_OFS_WAKE;
   always_comb begin
      if (wr_wake)
         wake_clr = reg_wdata;
      else if (reg_read && reg_addr == `PMAE_OFS_WAKE &&
               smi_ctl_ff[`PMAE_SMI_READ_CLR])
         wake_clr = wake_ff;
      else
         wake_clr = '0;
   end
   always_ff @(posedge mclk) begin
      if (reset)
         wake_ff <= `PMAE_RST_BYTE;
      else
         wake_ff <= ((wake_ff & ~wake_clr) | wake_set) &
                    `PMAE_MASK_WAKE;
   end

   // checks
   sequence s_wake_write1(int b);
      wr_wake && reg_wdata[b] && !wake_set[b];
   endsequence
   sequence s_serial_access;
      io_access.valid && io_access.addr == 16'h03f8 &&
      en_b_ff[`PMAE_B_WIN_LO];
   endsequence

   AST_ENABLE_RESET: assert property (@(posedge mclk)
      reset |=> en_a_ff == '0 && en_b_ff == '0 && en_c_ff == '0)
      else $error("enable registers not cleared by reset");
   AST_FDD_RANGE: assert property (@(posedge mclk) disable iff (reset)
      io_access.valid && io_access.addr == `PMAE_FDD_SEC_LO &&
      select_ff[`PMAE_SEL_FDD] |=> activity_events.floppy)
      else $error("alternate floppy range missed");
   AST_LPT_DRQ: assert property (@(posedge mclk) disable iff (reset)
      select_ff[2:1] == 2'h2 && en_b_ff[`PMAE_B_LPT_DRQ] &&
      pin_sync_ff.drq_req[3] |=> activity_events.parallel)
      else $error("parallel dma request three missed");
   AST_KBD: assert property (@(posedge mclk) disable iff (reset)
      activity_events.keyboard |-> $past(pin_sync_ff.irq1 ||
      pin_sync_ff.irq12))
      else $error("keyboard event without interrupt");
   AST_SERIAL_WIN: assert property (@(posedge mclk) disable iff (reset)
      s_serial_access |=> activity_events.serial)
      else $error("serial window access missed");
   AST_WAKE_CAUSE: assert property (@(posedge mclk) disable iff (reset)
      $rose(wake_ff[`PMAE_WAKE_PWR]) |-> standby_to_on_smi)
      else $error("wake status set without smi");
   AST_SMI_CAUSE: assert property (@(posedge mclk) disable iff (reset)
      standby_to_on_smi |-> $past(standby_expired))
      else $error("smi raised before standby expiry");
   AST_W1C: assert property (@(posedge mclk) disable iff (reset)
      s_wake_write1(`PMAE_WAKE_RTC) |=> !wake_ff[`PMAE_WAKE_RTC])
      else $error("write one did not clear wake status");
   AST_BUS_ACTIVITY_EVENT: assert property (@(posedge mclk) disable iff (reset)
      activity_events.bus_activity_event |->
      $past(threshold_ff[`PMAE_THR_ENABLE], 2))
      else $error("bus activity event while disabled");

endmodule

`default_nettype wire

// ### verif/pmae_far_model.sv
/*
 * far-side model: isa i/o cycles and peripheral pins for the detector.
 * assumes requests come from the bench on mclk.
 */
`default_nettype none

module pmae_far_model (
   // clock
   input  wire logic                         mclk,
   // requests from the bench
   input  wire logic                         go,
   input  wire logic [15:0]                  addr,
   input  wire logic                         press,
   input  wire logic [7:0]                   drq,
   input  wire logic                         irq,
   input  wire logic                         trdy,
   // towards the block
   output var  pmae_pkg::pmae_io_access_type io_access,
   output var  pmae_pkg::pmae_pin_type       pins
);
   // one i/o cycle per request; idle address shows the inverse
   always_ff @(posedge mclk) begin
      io_access <= {go, 1'b0, go ? addr : ~addr};
   end
   // pins idle unless driven; active-low lines inverted here
   always_ff @(posedge mclk) begin
      pins <= {drq, irq, 2'b01, 4'h0, 2'b00, 1'b1, ~press, 1'b0, ~trdy};
   end
endmodule

`default_nettype wire

// ### verif/pmae_activity_detect_tb_top.sv
/*
 * bench for the activity detector: registers, i/o events and wake.
 * assumes the far-side model and a 40 mhz mclk.
 */
`default_nettype none

module pmae_activity_detect_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                         mclk = 1'b0;
   logic                         reset = 1'b1;
   logic [7:0]                   reg_addr = 8'h00;
   logic [7:0]                   reg_wdata = 8'h00;
   logic                         reg_write = 1'b0;
   logic                         reg_read = 1'b0;
   logic [7:0]                   reg_rdata;
   logic                         go = 1'b0;
   logic [15:0]                  addr = 16'h0000;
   logic                         press = 1'b0;
   logic [7:0]                   drq = 8'h00;
   logic                         irq = 1'b0;
   logic                         trdy = 1'b0;
   logic                         grp_c = 1'b0;
   pmae_pkg::pmae_mem_access_type mem = '0;
   logic [31:0]                  smon = 32'h0000_0000;
   logic                         expired = 1'b0;
   logic                         smi;
   logic [7:0]                   d;
   pmae_pkg::pmae_io_access_type io_access;
   pmae_pkg::pmae_pin_type       pins;
   pmae_pkg::pmae_event_type     ev;
   int                           mismatches = 0;
   int                           n_tests = 0;
   int                           n_ev = 0;
   // offset, enable data, i/o address, expected events
   logic [41:0] rows [12] = '{
      {8'h70, 8'h01, 16'h03f8, 10'h010}, {8'h70, 8'h80, 16'h033f, 10'h010},
      {8'h70, 8'h02, 16'h02f7, 10'h000}, {8'h70, 8'h00, 16'h03ff, 10'h000},
      {8'h71, 8'h01, 16'h0378, 10'h008}, {8'h71, 8'h04, 16'h03be, 10'h008},
      {8'h6d, 8'h80, 16'h0f47, 10'h080}, {8'h6c, 8'h04, 16'h0200, 10'h080},
      {8'h6c, 8'h08, 16'h0338, 10'h080}, {8'h71, 8'h10, 16'h0066, 10'h002},
      {8'h68, 8'h00, 16'h03f3, 10'h020}, {8'h68, 8'h01, 16'h0377, 10'h020}};
   logic [7:0]  offs [12] = '{8'h68, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70,
                              8'h71, 8'h72, 8'h73, 8'h75, 8'h76, 8'h77};
   logic [7:0]  msks [12] = '{8'h07, 8'hff, 8'hff, 8'hbf, 8'h1f, 8'hff,
                              8'h3f, 8'h0d, 8'h00, 8'hff, 8'h7f, 8'h10};

   always #12.5 mclk = ~mclk;

   pmae_far_model u_far (.mclk(mclk), .go(go), .addr(addr), .press(press),
      .drq(drq), .irq(irq), .trdy(trdy),
      .io_access(io_access), .pins(pins));

   pmae_activity_detect u_dut (.mclk(mclk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .io_access(io_access),
      .mem_access(mem), .io_group_c_hit(grp_c), .pins(pins),
      .standby_monitor_enable(smon), .standby_expired(expired),
      .activity_events(ev), .standby_to_on_smi(smi));

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   // one-cycle register read, data taken the cycle after
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // verdict and end of run
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      #200us;
      mismatches++;
      results();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      for (int j = 0; j < 12; j++) begin
         rd(offs[j], d);
         chk(d, 0);
      end
      // table of i/o window cases
      foreach (rows[i]) begin
         wr(rows[i][41:34], rows[i][33:26]);
         @(posedge mclk);
         go <= 1'b1;
         addr <= rows[i][25:10];
         @(posedge mclk);
         go <= 1'b0;
         @(posedge mclk);
         #1 chk(ev, rows[i][9:0]);
         @(posedge mclk);
         #1 chk(ev, 0);
         wr(rows[i][41:34], 8'h00);
      end
      // dma request three, interrupt one, a-b page and group c traffic
      wr(8'h68, 8'h04);
      wr(8'h6e, 8'h84);
      wr(8'h6f, 8'h08);
      wr(8'h71, 8'h28);
      drq <= 8'h08;
      irq <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(ev, 10'h08c);
      mem <= '{1'b1, 32'h000a_0000};
      grp_c <= 1'b1;
      @(posedge mclk);
      mem <= '0;
      grp_c <= 1'b0;
      #1 chk(ev, 10'h0ce);
      drq <= 8'h00;
      irq <= 1'b0;
      // reserved bits read zero, full interval count kept
      for (int j = 0; j < 12; j++) begin
         wr(offs[j], 8'hff);
         rd(offs[j], d);
         chk(d, msks[j]);
         wr(offs[j], 8'h00);
      end
      wr(8'h80, 8'hff);
      rd(8'h80, d);
      chk(d, 0);
      // bus activity: four busy cycles per window of four
      trdy <= 1'b1;
      wr(8'h75, 8'h04);
      for (int t = 1; t <= 4; t += 3) begin
         wr(8'h76, 8'h40 | t[7:0]);
         repeat (8) @(posedge mclk);
         n_ev = 0;
         repeat (8) begin
            @(posedge mclk);
            #1 n_ev += ev.bus_activity_event;
         end
         chk(n_ev, t < 4 ? 2 : 0);
      end
      wr(8'h76, 8'h00);
      trdy <= 1'b0;
      // wake by power button only once standby has expired
      smon <= 32'h0020_0000;
      press <= 1'b1;
      repeat (8) @(posedge mclk);
      #1 chk(smi, 0);
      rd(8'h74, d);
      chk(d, 0);
      expired <= 1'b1;
      repeat (6) @(posedge mclk);
      #1 chk(smi, 1);
      press <= 1'b0;
      expired <= 1'b0;
      rd(8'h74, d);
      chk(d, 8'h10);
      wr(8'h74, 8'h33);
      rd(8'h74, d);
      chk(d, 0);
      results();
   end
endmodule

`default_nettype wire
